// ---- hdl/cct_timer.v ----
/*
  One timer instance: prescaler, counter, four capture/compare channels,
  complementary dead-time outputs, encoder and Hall decoding, link in/out,
  DMA request, sticky status with mask and one interrupt line.
  Assumes a single-master register port, channel pins from outside the
  clock domain, and a debug halt level on the same clock.
*/
// Contract
// R1 - The counter is 16 or 32 bits wide, fixed per instance by a parameter.
// R2 - The counter counts up or down and reloads on its own at each period end.
// R3 - A 16-bit prescaler drives the counter and four channels are provided.
// R4 - Each channel is capture, compare, PWM or single pulse as software picks.
// R5 - PWM may be edge aligned or centre aligned.
// R6 - The advanced variant drives complementary pairs with dead time between edges.
// R7 - The advanced PWM duty spans from fully off to fully on.
// R8 - The advanced variant also works as a full general-purpose timer.
// R9 - Timers link so one can reset, start or gate another.
// R10 - In debug halt the counter stops and the PWM outputs are off; Hall edges and link resets still clear the counter during halt.
// R11 - Each timer has its own DMA request output.
// R12 - The timer decodes quadrature encoder signals into counting.
// R13 - The timer decodes one to four Hall sensor outputs.
// R14 - The basic variant is a 16-bit up counter with prescaler, no channels, halted in debug.
// R15 - A general-purpose timer can run as a basic timer with its channels unused.
// R16 - Overflow and underflow raise an update event used for interrupt and DMA.
// R17 - Centre-aligned counting turns round at the reload value and at zero.
`include "cct_defs.vh"

module cct_timer #(
  parameter CNT_W   = 16,
  parameter HAS_CH  = 1,
  parameter HAS_CMP = 0
) (
  input  wire                 i_sys_clk,
  input  wire                 i_srst,
  input  wire [`CCT_AW-1:0]   i_addr,
  input  wire [31:0]          i_wdata,
  input  wire                 i_wr,
  input  wire                 i_rd,
  output reg  [31:0]          o_rdata,
  input  wire                 i_dbg_halt,
  input  wire                 i_link_trig,
  output reg                  o_link_trig,
  output reg                  o_dma_req,
  output wire                 o_irq,
  input  wire [3:0]           i_ch,
  output wire [3:0]           o_ch,
  output wire [3:0]           o_ch_oe_n,
  output wire [3:0]           o_ch_n
);
  localparam [CNT_W-1:0] ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

  function is_out;
    input [2:0] m;
    begin
      is_out = (m == `CCT_CH_TOG) || (m == `CCT_CH_PWM) || (m == `CCT_CH_ONE);
    end
  endfunction

  function is_pwm;
    input [2:0] m;
    begin
      is_pwm = (m == `CCT_CH_PWM) || (m == `CCT_CH_ONE);
    end
  endfunction

  reg [`CCT_CTRL_W-1:0]  ctrl_q;
  reg [`CCT_PSC_W-1:0]   psc_q;
  reg [`CCT_PSC_W-1:0]   pcnt_q;
  reg [CNT_W-1:0]        arr_q;
  reg [CNT_W-1:0]        cnt_q;
  reg [CNT_W-1:0]        cnt_d;
  reg                    cdown_q;
  reg                    cdown_d;
  reg [`CCT_STS_W-1:0]   sts_q;
  reg [`CCT_STS_W-1:0]   msk_q;
  reg [`CCT_CHCFG_W-1:0] chcfg_q;
  reg [`CCT_DT_W-1:0]    dt_q;
  reg [CNT_W-1:0]        ccr_q [0:3];
  reg [3:0]              s1_q;
  reg [3:0]              s2_q;
  reg [3:0]              s3_q;
  reg [3:0]              stab_q;
  reg [3:0]              prev_q;
  reg [3:0]              ref_q;
  reg                    trig_prev_q;
  reg                    upd;
  reg [3:0]              cap_ev;
  reg [3:0]              hit_ev;
  reg                    one_sel;
  integer                i;

  wire [1:0] in_mode = ctrl_q[`CCT_CTRL_IN_HI:`CCT_CTRL_IN_LO];
  wire [1:0] sl_mode = ctrl_q[`CCT_CTRL_SL_HI:`CCT_CTRL_SL_LO];
  wire       run     = ctrl_q[`CCT_CTRL_EN];
  wire       centre  = ctrl_q[`CCT_CTRL_CTR] && (HAS_CH != 0); // R14
  wire       down    = ctrl_q[`CCT_CTRL_DOWN] && (HAS_CH != 0); // R14
  wire       trig_re = i_link_trig && !trig_prev_q;
  wire       gate_ok = (sl_mode != `CCT_SL_GATE) || i_link_trig; // R9
  wire       wr_cnt  = i_wr && (i_addr == `CCT_OFS_CNT);
  wire       wr_sts  = i_wr && (i_addr == `CCT_OFS_STS);

  // Debug halt freezes the prescaler and counter steps; Hall edges and link resets still clear the counter
  wire live     = run && !i_dbg_halt && gate_ok; // R10 R14
  wire psc_tick = live && (pcnt_q == psc_q); // R3

  // Quadrature: any change of either line is one count, direction from phase
  wire enc_on  = (HAS_CH != 0) && (in_mode == `CCT_IN_ENC);
  wire enc_evt = enc_on && ((stab_q[0] ^ prev_q[0]) || (stab_q[1] ^ prev_q[1])); // R12
  wire enc_up  = stab_q[0] ^ prev_q[1]; // R12

  // Hall: parity of up to four sensor lines flips at each sensor edge
  wire hall_evt = (HAS_CH != 0) && (in_mode == `CCT_IN_HALL) && run &&
                  ((^stab_q) != (^prev_q)); // R13

  wire step = enc_on ? (live && enc_evt) : psc_tick;
  wire sl_rst = (sl_mode == `CCT_SL_RESET) && trig_re; // R9

  always @* begin
    cnt_d   = cnt_q;
    cdown_d = cdown_q;
    upd     = 1'b0;
    if (wr_cnt) begin
      cnt_d = i_wdata[CNT_W-1:0];
    end else if (hall_evt || sl_rst) begin
      cnt_d = ZERO;
    end else if (step) begin
      if (centre && !enc_on) begin
        if (!cdown_q) begin
          if (cnt_q >= arr_q) begin
            cnt_d   = arr_q - ONE; // R17
            cdown_d = 1'b1;
            upd     = 1'b1; // R16
          end else begin
            cnt_d = cnt_q + ONE;
          end
        end else begin
          if (cnt_q == ZERO) begin
            cnt_d   = ONE; // R17
            cdown_d = 1'b0;
            upd     = 1'b1; // R16
          end else begin
            cnt_d = cnt_q - ONE;
          end
        end
      end else if (enc_on ? !enc_up : down) begin
        if (cnt_q == ZERO) begin
          cnt_d = arr_q; // R2
          upd   = 1'b1; // R16
        end else begin
          cnt_d = cnt_q - ONE;
        end
      end else begin
        if (cnt_q >= arr_q) begin
          cnt_d = ZERO; // R2
          upd   = 1'b1; // R16
        end else begin
          cnt_d = cnt_q + ONE;
        end
      end
    end
  end

  // Channel events and single-pulse mode select
  always @* begin
    one_sel = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      cap_ev[i] = (HAS_CH != 0) && (chcfg_q[4*i +: 3] == `CCT_CH_CAP) &&
                  (stab_q[i] != prev_q[i]) && (stab_q[i] != chcfg_q[4*i+3]); // R4
      hit_ev[i] = (HAS_CH != 0) && is_out(chcfg_q[4*i +: 3]) && step &&
                  (cnt_d == ccr_q[i]);
      if (chcfg_q[4*i +: 3] == `CCT_CH_ONE)
        one_sel = 1'b1;
    end
  end

  wire [`CCT_STS_W-1:0] sts_set = {sl_mode != `CCT_SL_NONE && trig_re,
                                   hit_ev | cap_ev |
                                   {3'h0, hall_evt}, upd}; // R16

  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      ctrl_q      <= `CCT_CTRL_RST;
      psc_q       <= `CCT_PSC_RST;
      pcnt_q      <= `CCT_PSC_RST;
      arr_q       <= {CNT_W{1'b1}};
      cnt_q       <= ZERO;
      cdown_q     <= 1'b0;
      sts_q       <= {`CCT_STS_W{1'b0}};
      msk_q       <= {`CCT_STS_W{1'b0}};
      chcfg_q     <= {`CCT_CHCFG_W{1'b0}};
      dt_q        <= `CCT_DT_RST;
      trig_prev_q <= 1'b0;
      o_link_trig <= 1'b0;
      o_dma_req   <= 1'b0;
      o_rdata     <= 32'h0000_0000;
      for (i = 0; i < 4; i = i + 1) begin
        ccr_q[i] <= ZERO;
      end
    end else begin
      trig_prev_q <= i_link_trig;
      cnt_q       <= cnt_d;
      cdown_q     <= centre ? cdown_d : 1'b0;
      o_link_trig <= upd; // R9
      o_dma_req   <= upd && ctrl_q[`CCT_CTRL_DMAEN]; // R11
      // A fresh event wins over a clear in the same cycle
      sts_q <= (sts_q & ~(wr_sts ? i_wdata[`CCT_STS_W-1:0] : {`CCT_STS_W{1'b0}}))
               | sts_set;

      if (wr_cnt || sl_rst || !run)
        pcnt_q <= `CCT_PSC_RST;
      else if (psc_tick)
        pcnt_q <= `CCT_PSC_RST;
      else if (live)
        pcnt_q <= pcnt_q + 1'b1; // R3

      if (i_wr && i_addr == `CCT_OFS_CTRL)
        ctrl_q <= i_wdata[`CCT_CTRL_W-1:0];
      else if (sl_mode == `CCT_SL_START && trig_re)
        ctrl_q[`CCT_CTRL_EN] <= 1'b1; // R9
      else if (upd && one_sel)
        ctrl_q[`CCT_CTRL_EN] <= 1'b0; // R4

      if (i_wr && i_addr == `CCT_OFS_PSC)
        psc_q <= i_wdata[`CCT_PSC_W-1:0];
      if (i_wr && i_addr == `CCT_OFS_ARR)
        arr_q <= i_wdata[CNT_W-1:0];
      if (i_wr && i_addr == `CCT_OFS_MSK)
        msk_q <= i_wdata[`CCT_STS_W-1:0];
      if (i_wr && i_addr == `CCT_OFS_CHCFG && HAS_CH != 0)
        chcfg_q <= i_wdata[`CCT_CHCFG_W-1:0];
      if (i_wr && i_addr == `CCT_OFS_DT && HAS_CMP != 0)
        dt_q <= i_wdata[`CCT_DT_W-1:0];

      for (i = 0; i < 4; i = i + 1) begin
        if (cap_ev[i])
          ccr_q[i] <= cnt_q; // R4
        else if (i == 0 && hall_evt)
          ccr_q[i] <= cnt_q; // R13
        else if (i_wr && HAS_CH != 0 && i_addr == `CCT_OFS_CCR0 + 4 * i)
          ccr_q[i] <= i_wdata[CNT_W-1:0];
      end

      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        case (i_addr)
          `CCT_OFS_CTRL:  o_rdata[`CCT_CTRL_W-1:0]  <= ctrl_q;
          `CCT_OFS_PSC:   o_rdata[`CCT_PSC_W-1:0]   <= psc_q;
          `CCT_OFS_ARR:   o_rdata[CNT_W-1:0]        <= arr_q;
          `CCT_OFS_CNT:   o_rdata[CNT_W-1:0]        <= cnt_q;
          `CCT_OFS_STS:   o_rdata[`CCT_STS_W-1:0]   <= sts_q;
          `CCT_OFS_MSK:   o_rdata[`CCT_STS_W-1:0]   <= msk_q;
          `CCT_OFS_CHCFG: o_rdata[`CCT_CHCFG_W-1:0] <= chcfg_q;
          `CCT_OFS_DT:    o_rdata[`CCT_DT_W-1:0]    <= dt_q;
          `CCT_OFS_CCR0:  o_rdata[CNT_W-1:0]        <= ccr_q[0];
          6'h24:          o_rdata[CNT_W-1:0]        <= ccr_q[1];
          6'h28:          o_rdata[CNT_W-1:0]        <= ccr_q[2];
          `CCT_OFS_CCR3:  o_rdata[CNT_W-1:0]        <= ccr_q[3];
          default:        o_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign o_irq = |(sts_q & msk_q);

  // Pin inputs: three flops, a change is taken once the last two agree
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      s1_q   <= 4'h0;
      s2_q   <= 4'h0;
      s3_q   <= 4'h0;
      stab_q <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      s1_q   <= i_ch;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      stab_q <= (s2_q & s3_q) | (stab_q & (s2_q ^ s3_q));
      prev_q <= stab_q;
    end
  end

  // Reference levels: PWM below compare value is active, so a compare
  // value of zero is always off and one above the reload always on
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      ref_q <= 4'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (is_pwm(chcfg_q[4*i +: 3]))
          ref_q[i] <= (cnt_d < ccr_q[i]) ^ chcfg_q[4*i+3]; // R5 R7
        else if (chcfg_q[4*i +: 3] == `CCT_CH_TOG)
          ref_q[i] <= ref_q[i] ^ hit_ev[i]; // R4
        else
          ref_q[i] <= 1'b0;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      cct_deadtime #(
        .DT_W (`CCT_DT_W)
      ) u_dt (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_ref     (ref_q[g]),
        .i_cmp_en  ((HAS_CMP != 0) && chcfg_q[`CCT_CHCFG_CMP + g]), // R6 R8
        .i_kill    (i_dbg_halt || !is_out(chcfg_q[4*g +: 3])), // R10
        .i_dt      (dt_q),
        .o_p       (o_ch[g]),
        .o_n       (o_ch_n[g])
      );
      assign o_ch_oe_n[g] = !is_out(chcfg_q[4*g +: 3]) || (HAS_CH == 0); // R15
    end
  endgenerate
  // R1: CNT_W sets the counter width per instance
endmodule // cct_timer

// ---- common/cct_defs.vh ----
/*
  Register offsets, field positions, reset values and codes for the
  capture/compare timer.
  Assumes byte addresses on a 6-bit register port, one word per register.
*/
`ifndef CCT_DEFS_VH
`define CCT_DEFS_VH

`define CCT_AW          6
`define CCT_OFS_CTRL    6'h00
`define CCT_OFS_PSC     6'h04
`define CCT_OFS_ARR     6'h08
`define CCT_OFS_CNT     6'h0c
`define CCT_OFS_STS     6'h10
`define CCT_OFS_MSK     6'h14
`define CCT_OFS_CHCFG   6'h18
`define CCT_OFS_DT      6'h1c
`define CCT_OFS_CCR0    6'h20
`define CCT_OFS_CCR3    6'h2c

// Control register fields
`define CCT_CTRL_EN     0
`define CCT_CTRL_DOWN   1
`define CCT_CTRL_CTR    2
`define CCT_CTRL_DMAEN  3
`define CCT_CTRL_IN_LO  4
`define CCT_CTRL_IN_HI  5
`define CCT_CTRL_SL_LO  6
`define CCT_CTRL_SL_HI  7
`define CCT_CTRL_W      8
`define CCT_CTRL_RST    8'h00

// Input decode modes
`define CCT_IN_NONE     2'h0
`define CCT_IN_ENC      2'h1
`define CCT_IN_HALL     2'h2

// Link slave modes
`define CCT_SL_NONE     2'h0
`define CCT_SL_RESET    2'h1
`define CCT_SL_START    2'h2
`define CCT_SL_GATE     2'h3

// Channel modes, 4 bits per channel: {polarity, mode}
`define CCT_CH_OFF      3'h0
`define CCT_CH_CAP      3'h1
`define CCT_CH_TOG      3'h2
`define CCT_CH_PWM      3'h3
`define CCT_CH_ONE      3'h4
`define CCT_CHCFG_W     20
`define CCT_CHCFG_CMP   16

// Status and mask bits: update, four channel events, link trigger
`define CCT_STS_W       6
`define CCT_STS_UPD     0
`define CCT_STS_CC0     1
`define CCT_STS_TRG     5

`define CCT_PSC_W       16
`define CCT_PSC_RST     16'h0000
`define CCT_DT_W        8
`define CCT_DT_RST      8'h00

`endif

// ---- hdl/cct_deadtime.v ----
/*
  Complementary output pair with dead-time insertion for one channel.
  Assumes i_ref is a registered reference level on the same clock.
*/
module cct_deadtime #(
  parameter DT_W = 8
) (
  input  wire            i_sys_clk,
  input  wire            i_srst,
  input  wire            i_ref,
  input  wire            i_cmp_en,
  input  wire            i_kill,
  input  wire [DT_W-1:0] i_dt,
  output reg             o_p,
  output reg             o_n
);
  reg            last_q;
  reg [DT_W-1:0] wait_q;

  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      last_q <= 1'b0;
      wait_q <= {DT_W{1'b0}};
      o_p    <= 1'b0;
      o_n    <= 1'b0;
    end else if (i_kill) begin
      last_q <= 1'b0;
      wait_q <= {DT_W{1'b0}};
      o_p    <= 1'b0;
      o_n    <= 1'b0;
    end else if (!i_cmp_en) begin
      last_q <= i_ref;
      wait_q <= {DT_W{1'b0}};
      o_p    <= i_ref;
      o_n    <= 1'b0;
    end else if (i_ref != last_q) begin
      // Both sides off for i_dt cycles while the power stage turns over;
      // a zero dead time switches straight across so full duty stays reachable
      last_q <= i_ref; // R6
      if (i_dt == {DT_W{1'b0}}) begin
        wait_q <= {DT_W{1'b0}};
        o_p    <= i_ref;
        o_n    <= ~i_ref;
      end else begin
        wait_q <= i_dt - 1'b1;
        o_p    <= 1'b0;
        o_n    <= 1'b0;
      end
    end else if (wait_q != {DT_W{1'b0}}) begin
      wait_q <= wait_q - 1'b1;
    end else begin
      o_p <= last_q;
      o_n <= ~last_q; // R6
    end
  end
endmodule // cct_deadtime

// ---- dv/cct_timer_props.sv ----
/* Port checks for the timer, bound into every instance.
   Assumes one clock and a synchronous active-high reset. */
module cct_timer_props (
  input wire logic        i_sys_clk,
  input wire logic        i_srst,
  input wire logic        i_rd,
  input wire logic        i_dbg_halt,
  input wire logic [31:0] o_rdata,
  input wire logic        o_link_trig,
  input wire logic        o_dma_req,
  input wire logic        o_irq,
  input wire logic [3:0]  o_ch,
  input wire logic [3:0]  o_ch_oe_n,
  input wire logic [3:0]  o_ch_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // Three cycles of halt leave no room for an update already on its way
  sequence s_halted;
    i_dbg_halt [*3];
  endsequence
  sequence s_quiet;
    !o_link_trig [*2];
  endsequence
  property p_rd_idle;
    !i_rd |=> o_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_rst_out;
    $fell(i_srst) |-> o_ch == 4'h0 && o_ch_n == 4'h0 && o_ch_oe_n == 4'hf && !o_irq;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  property p_rst_quiet;
    $fell(i_srst) |-> s_quiet;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("update right after reset");
  property p_no_overlap;
    (o_ch & o_ch_n) == 4'h0;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pair both high");
  property p_halt_off;
    i_dbg_halt |=> (o_ch | o_ch_n) == 4'h0;
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("output during halt");
  property p_halt_noupd;
    s_halted |=> !o_link_trig;
  endproperty
  a_halt_noupd: assert property (p_halt_noupd) else $error("update in halt");
  property p_halt_nodma;
    s_halted |=> !o_dma_req;
  endproperty
  a_halt_nodma: assert property (p_halt_nodma) else $error("dma in halt");
  property p_dma_link;
    o_dma_req |-> o_link_trig;
  endproperty
  a_dma_link: assert property (p_dma_link) else $error("dma without update");
endmodule // cct_timer_props
bind cct_timer cct_timer_props u_props (
  .i_sys_clk  (i_sys_clk),
  .i_srst     (i_srst),
  .i_rd       (i_rd),
  .i_dbg_halt (i_dbg_halt),
  .o_rdata    (o_rdata),
  .o_link_trig(o_link_trig),
  .o_dma_req  (o_dma_req),
  .o_irq      (o_irq),
  .o_ch       (o_ch),
  .o_ch_oe_n  (o_ch_oe_n),
  .o_ch_n     (o_ch_n)
);

// ---- dv/cct_pin_model.sv ----
/* Far-side pins: quadrature encoder on channels 0 and 1, sensor levels
   on channels 2 and 3. Assumes one-cycle step requests on the clock. */
module cct_pin_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_step,
  input  wire logic       i_back,
  input  wire logic [1:0] i_aux,
  output wire logic [3:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_q = 2'h0;
  always @(posedge i_sys_clk) begin
    if (i_step) phase_q <= i_back ? phase_q - 2'h1 : phase_q + 2'h1;
  end
  // Gray order: one line moves per step, channel 0 leads going forward
  assign o_pins = {i_aux, phase_q[1], phase_q[1] ^ phase_q[0]};
endmodule // cct_pin_model

// ---- dv/cct_timer_tb_top.sv ----
/* Bench for one advanced timer instance with an encoder on its pins.
   Assumes the port checker is bound from its own file. */
`include "cct_defs.vh"
module cct_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk   = 1'b0;
  logic        i_srst      = 1'b1;
  logic [5:0]  i_addr      = 6'h00;
  logic [31:0] i_wdata     = 32'h0;
  logic        i_wr        = 1'b0;
  logic        i_rd        = 1'b0;
  logic        i_dbg_halt  = 1'b0;
  logic        i_link_trig = 1'b0;
  logic        step        = 1'b0;
  logic        back        = 1'b0;
  logic [3:0]  pins;
  logic [31:0] o_rdata;
  logic        o_link_trig;
  logic        o_dma_req;
  logic        o_irq;
  logic [3:0]  o_ch;
  logic [3:0]  o_ch_oe_n;
  logic [3:0]  o_ch_n;
  logic [31:0] v;
  int          failures    = 0;
  int          tests_run   = 0;
  int          seed        = 32'h525a00f4;
  int          n;
  int          hi;
  int          lo;
  int          psc;
  int          arr;
  localparam logic [5:0] REGS [8] = '{`CCT_OFS_CTRL, `CCT_OFS_PSC, `CCT_OFS_ARR,
    `CCT_OFS_CNT, `CCT_OFS_STS, `CCT_OFS_MSK, `CCT_OFS_DT, 6'h30};

  always #5 i_sys_clk = ~i_sys_clk;

  cct_timer #(.CNT_W(16), .HAS_CH(1), .HAS_CMP(1)) u_dut (
    .i_sys_clk  (i_sys_clk),
    .i_srst     (i_srst),
    .i_addr     (i_addr),
    .i_wdata    (i_wdata),
    .i_wr       (i_wr),
    .i_rd       (i_rd),
    .o_rdata    (o_rdata),
    .i_dbg_halt (i_dbg_halt),
    .i_link_trig(i_link_trig),
    .o_link_trig(o_link_trig),
    .o_dma_req  (o_dma_req),
    .o_irq      (o_irq),
    .i_ch       (pins),
    .o_ch       (o_ch),
    .o_ch_oe_n  (o_ch_oe_n),
    .o_ch_n     (o_ch_n)
  );
  cct_pin_model u_pins (
    .i_sys_clk(i_sys_clk),
    .i_step   (step),
    .i_back   (back),
    .i_aux    (2'h0),
    .o_pins   (pins)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic wait_upd(output int c);
    c = 0;
    do begin
      @(posedge i_sys_clk);
      #1 c++;
    end while (o_link_trig !== 1'b1 && c < 3000);
    if (c >= 3000) begin
      failures++;
      finish_test();
    end
  endtask
  task automatic count_hi(input int len, output int p, output int q);
    p = 0;
    q = 0;
    repeat (len) begin
      @(posedge i_sys_clk);
      #1 p += (o_ch[0] === 1'b1);
      q += (o_ch_n[0] === 1'b1);
    end
  endtask

  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    foreach (REGS[i]) begin
      rd(REGS[i], v);
      chk("reset value", v, REGS[i] == `CCT_OFS_ARR ? 32'hffff : 32'h0);
    end
    wr(6'h30, 32'hffffffff);
    rd(6'h30, v);
    chk("unmapped", v, 32'h0);
    wr(`CCT_OFS_PSC, 32'hffffffff);
    rd(`CCT_OFS_PSC, v);
    chk("prescaler width", v, 32'hffff);
    // Modes up, down, centre with random prescale and reload
    for (int m = 0; m < 3; m++) begin
      psc = {$random(seed)} % 4;
      arr = 3 + {$random(seed)} % 6;
      wr(`CCT_OFS_PSC, psc);
      wr(`CCT_OFS_ARR, arr);
      wr(`CCT_OFS_CNT, 32'h0);
      wr(`CCT_OFS_CTRL, 32'h9 | (m == 1 ? 32'h2 : 32'h0) | (m == 2 ? 32'h4 : 32'h0));
      wait_upd(n);
      chk("dma request", o_dma_req, 1'b1);
      wait_upd(n);
      chk("period", n, (m == 2 ? arr : arr + 1) * (psc + 1));
      wr(`CCT_OFS_CTRL, 32'h0);
      rd(`CCT_OFS_STS, v);
      chk("update flag", v[0], 1'b1);
      wr(`CCT_OFS_MSK, 32'h1);
      chk("irq set", o_irq, 1'b1);
      wr(`CCT_OFS_STS, 32'h1);
      chk("irq clear", o_irq, 1'b0);
      wr(`CCT_OFS_MSK, 32'h0);
    end
    wr(`CCT_OFS_PSC, 32'h0);
    wr(`CCT_OFS_ARR, 32'h9);
    wr(`CCT_OFS_CHCFG, 32'h10003);
    wr(`CCT_OFS_CTRL, 32'h1);
    chk("drive enable", o_ch_oe_n[0], 1'b0);
    for (int k = 0; k < 7; k++) begin
      n = k == 0 ? 0 : k == 1 ? 10 : k == 2 ? 5 : {$random(seed)} % 11;
      wr(`CCT_OFS_CCR0, n);
      wr(`CCT_OFS_DT, k == 2 ? 32'h2 : 32'h0);
      repeat (25) @(posedge i_sys_clk);
      count_hi(10, hi, lo);
      chk("duty", hi, k == 2 ? 3 : n);
      chk("complement", lo, k == 2 ? 3 : 10 - n);
    end
    wr(`CCT_OFS_CCR0, 32'h5);
    wr(`CCT_OFS_CTRL, 32'h5);
    repeat (40) @(posedge i_sys_clk);
    count_hi(18, hi, lo);
    chk("centre duty", hi, 9);
    wr(`CCT_OFS_CTRL, 32'h1);
    wr(`CCT_OFS_CCR0, 32'ha);
    @(posedge i_sys_clk) i_dbg_halt <= 1'b1;
    wr(`CCT_OFS_CNT, 32'h3);
    repeat (20) @(posedge i_sys_clk);
    rd(`CCT_OFS_CNT, v);
    chk("frozen count", v, 32'h3);
    chk("halted pair", {o_ch_n[0], o_ch[0]}, 2'h0);
    @(posedge i_sys_clk) i_dbg_halt <= 1'b0;
    wr(`CCT_OFS_ARR, 32'hffff);
    wr(`CCT_OFS_CTRL, 32'hc1);
    wr(`CCT_OFS_CNT, 32'h0);
    repeat (20) @(posedge i_sys_clk);
    rd(`CCT_OFS_CNT, v);
    chk("gate shut", v, 32'h0);
    @(posedge i_sys_clk) i_link_trig <= 1'b1;
    repeat (20) @(posedge i_sys_clk);
    rd(`CCT_OFS_STS, v);
    chk("link flag", v[5], 1'b1);
    rd(`CCT_OFS_CNT, v);
    chk("gate open", v == 32'h0, 1'b0);
    @(posedge i_sys_clk) i_link_trig <= 1'b0;
    wr(`CCT_OFS_CHCFG, 32'h0);
    wr(`CCT_OFS_CTRL, 32'h11);
    wr(`CCT_OFS_CNT, 32'h0);
    // Five steps forward, two back; spacing clears the pin synchroniser
    for (int k = 0; k < 7; k++) begin
      @(posedge i_sys_clk) step <= 1'b1;
      back <= (k >= 5);
      @(posedge i_sys_clk) step <= 1'b0;
      repeat (10) @(posedge i_sys_clk);
    end
    rd(`CCT_OFS_CNT, v);
    chk("encoder count", v, 32'h3);
    finish_test();
  end
endmodule // cct_timer_tb_top
